// >>> logic/rrb_ctrl.sv
`timescale 1ns/1ps
module rrb_ctrl #(
  parameter logic [7:0] STRENGTH_BASE = 8'h0a,
  parameter int FB_DEPTH = 128
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic sleep_transmit_pin_i,
  input wire rrb_pkg::rrb_rx_s rx_i,
  output rrb_pkg::rrb_tx_s tx_o,
  output logic rx_start_o,
  output logic frame_complete_o,
  output logic [11:0] freq_corr_o
);
  import rrb_pkg::*;

  // =====================================================
  // link side: serial shifter on the host clock
  logic [2:0] bit_cnt_reg;
  logic [6:0] sh_in_reg;
  logic [7:0] out_sh_reg;
  logic [7:0] byte_hold_reg;
  logic byte_tgl_reg;
  logic [7:0] rd_hold_reg;

  // the select line ends the frame; the clock stands still outside it
  always_ff @(posedge sclk_i or posedge sel_n_i)
  begin
    if (sel_n_i)
    begin
      bit_cnt_reg <= 3'h0;
      sh_in_reg <= 7'h00;
      out_sh_reg <= 8'h00;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      sh_in_reg <= {sh_in_reg[5:0], mosi_i};
      out_sh_reg <= (bit_cnt_reg == 3'h7) ? rd_hold_reg : {out_sh_reg[6:0], 1'b0};
    end
  end

  // the toggle must keep its parity across frames, so only reset clears it
  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      byte_hold_reg <= 8'h00;
      byte_tgl_reg <= 1'b0;
    end
    else if (!sel_n_i && bit_cnt_reg == 3'h7)
    begin
      byte_hold_reg <= {sh_in_reg, mosi_i};
      byte_tgl_reg <= ~byte_tgl_reg;
    end
  end

  assign miso_o = out_sh_reg[7];
  assign miso_oe_o = ~sel_n_i;

  // =====================================================
  // crossings into the core clock: three stages, change counts when two agree
  localparam int N_SYNC = 3;
  wire [N_SYNC-1:0] async_w = {sleep_transmit_pin_i, sel_n_i, byte_tgl_reg};
  logic [2:0] sync_reg [N_SYNC];
  logic [N_SYNC-1:0] lvl_reg;
  logic [N_SYNC-1:0] lvl_prev_reg;

  for (genvar gi = 0; gi < N_SYNC; gi++)
  begin : g_sync
    always_ff @(posedge clk_i)
    begin
      if (!rst_n_i)
      begin
        sync_reg[gi] <= {3{SYNC_IDLE[gi]}};
        lvl_reg[gi] <= SYNC_IDLE[gi];
        lvl_prev_reg[gi] <= SYNC_IDLE[gi];
      end
      else
      begin
        sync_reg[gi] <= {sync_reg[gi][1:0], async_w[gi]};
        lvl_reg[gi] <= (sync_reg[gi][1] == sync_reg[gi][2]) ? sync_reg[gi][2] : lvl_reg[gi];
        lvl_prev_reg[gi] <= lvl_reg[gi];
      end
    end
  end

  wire byte_evt_w = (lvl_reg[0] ^ lvl_prev_reg[0]) & ~lvl_reg[1];
  wire sel_high_w = lvl_reg[1];
  wire sel_rise_w = lvl_reg[1] & ~lvl_prev_reg[1];
  wire slp_rise_w = lvl_reg[2] & ~lvl_prev_reg[2];

  // =====================================================
  // registers and frame buffer
  rrb_state_e state_reg, state_next;
  rrb_state_e ret_state_reg;
  logic [POWER_MSB:0] power_reg;
  logic safe_mode_reg;
  logic path_dis_reg;
  logic [SENS_MSB:0] sens_reg;
  logic fcs_ok_reg;
  logic [7:0] ed_reg;
  logic locked_reg;
  logic [7:0] fb_mem [FB_DEPTH];
  logic first_reg;
  logic [1:0] acc_reg;
  logic [6:0] ptr_reg;

  // host transaction decode
  wire is_cmd_byte_w = byte_evt_w & first_reg;
  wire is_data_byte_w = byte_evt_w & ~first_reg;
  wire [5:0] reg_addr_w = is_cmd_byte_w ? byte_hold_reg[5:0] : ptr_reg[5:0];
  wire reg_wr_w = is_data_byte_w & (acc_reg == ACC_REG_WRITE);
  wire fb_wr_w = is_data_byte_w & (acc_reg == ACC_FB_WRITE);
  wire cmd_vld_w = reg_wr_w & (reg_addr_w == OFS_STATE_CMD);
  wire [4:0] cmd_w = byte_hold_reg[CMD_MSB:0];
  wire frame_read_done_w = sel_rise_w & (acc_reg == ACC_FB_READ) & ~first_reg;

  function automatic logic cmd_is(input logic vld, input logic [4:0] cmd, input logic [4:0] code);
    cmd_is = vld && (cmd == code);
  endfunction

  // register read selection
  logic [7:0] reg_rd_w;
  assign reg_rd_w =
    (reg_addr_w == OFS_STATE_CMD) ? {5'h00, state_reg} :
    (reg_addr_w == OFS_TX_POWER) ? {4'h0, power_reg} :
    (reg_addr_w == OFS_STRENGTH) ? {fcs_ok_reg, 2'b00, rx_i.rssi[4:0]} :
    (reg_addr_w == OFS_ENERGY) ? ed_reg :
    (reg_addr_w == OFS_CTRL_TWO) ? {safe_mode_reg, 7'h00} :
    (reg_addr_w == OFS_RX_SYNC) ? {path_dis_reg, 3'h0, sens_reg} :
    8'h00;

  // =====================================================
  // receive gating: threshold = base + 3 * (level - 1)
  wire [8:0] thr_w = {1'b0, STRENGTH_BASE} + {4'h0, sens_reg, 1'b0} + {5'h00, sens_reg} - 9'd3;
  wire strength_ok_w = (sens_reg == SENS_RST) | ({1'b0, rx_i.rssi} > thr_w);
  wire rx_listen_w = (state_reg == st_rx_on) | (state_reg == st_autoack_rx_on);
  // only the listening states gate; a frame in progress is never cut short
  wire shr_ok_w = rx_i.shr_det & rx_listen_w & ~path_dis_reg & ~locked_reg & strength_ok_w;
  wire rx_busy_w = (state_reg == st_rx_busy) | (state_reg == st_autoack_rx_busy);
  wire rx_end_w = rx_busy_w & rx_i.frame_end;

  // =====================================================
  // transmit sequencing
  logic [11:0] tx_cnt_reg;
  logic mod_on_reg;
  logic [6:0] tx_ptr_reg;
  logic nib_reg;
  logic [4:0] chip_idx_reg;
  logic [5:0] chip_div_reg;
  logic [7:0] lqi_reg;
  logic [6:0] wptr_reg;
  rrb_tx_s tx_reg;

  wire tx_ready_w = (state_reg == st_pll_on) | (state_reg == st_retry_transmit_state);
  wire tx_trig_w = tx_ready_w & (slp_rise_w | cmd_is(cmd_vld_w, cmd_w, CMD_TX_START));
  wire tx_busy_w = state_reg == st_tx_busy;
  wire chip_tick_w = tx_busy_w & mod_on_reg & (chip_div_reg == 6'(CHIP_CYC - 1));
  wire [6:0] tx_len_w = fb_mem[0][6:0];
  wire sym_end_w = chip_tick_w & (chip_idx_reg == 5'h1f);
  wire tx_done_w = sym_end_w & nib_reg & (tx_ptr_reg == tx_len_w);
  wire [7:0] tx_byte_w = fb_mem[tx_ptr_reg];
  wire [3:0] tx_sym_w = nib_reg ? tx_byte_w[7:4] : tx_byte_w[3:0];

  // symbols 1..7 rotate symbol 0 by four chips each; 8..15 also flip odd chips
  function automatic logic [31:0] chip_seq(input logic [3:0] sym);
    logic [31:0] seq;
    seq = CHIP_BASE;
    for (int k = 0; k < 7; k++)
    begin
      if (k < int'(sym[2:0]))
        seq = {seq[3:0], seq[31:4]};
    end
    chip_seq = sym[3] ? (seq ^ CHIP_ODD_MASK) : seq;
  endfunction

  wire [31:0] chips_w = chip_seq(tx_sym_w);

  // =====================================================
  // operating state; unlisted command codes leave it alone
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      st_transceiver_off_state, st_pll_on:
      begin
        if (cmd_is(cmd_vld_w, cmd_w, CMD_RX_ON))
          state_next = st_rx_on;
        else if (cmd_is(cmd_vld_w, cmd_w, CMD_AUTOACK_RX))
          state_next = st_autoack_rx_on;
        else if (cmd_is(cmd_vld_w, cmd_w, CMD_RETRY_TX))
          state_next = st_retry_transmit_state;
        else if (cmd_is(cmd_vld_w, cmd_w, CMD_PLL_ON))
          state_next = st_pll_on;
        else if (cmd_is(cmd_vld_w, cmd_w, CMD_OFF))
          state_next = st_transceiver_off_state;
        else if (tx_trig_w)
          state_next = st_tx_busy;
      end
      st_rx_on, st_autoack_rx_on:
      begin
        if (shr_ok_w)
          state_next = (state_reg == st_rx_on) ? st_rx_busy : st_autoack_rx_busy;
        else if (cmd_is(cmd_vld_w, cmd_w, CMD_PLL_ON))
          state_next = st_pll_on;
        else if (cmd_is(cmd_vld_w, cmd_w, CMD_OFF))
          state_next = st_transceiver_off_state;
      end
      st_rx_busy, st_autoack_rx_busy:
      begin
        if (rx_i.frame_end)
          state_next = (state_reg == st_rx_busy) ? st_rx_on : st_autoack_rx_on;
      end
      st_retry_transmit_state:
      begin
        if (tx_trig_w)
          state_next = st_tx_busy;
        else if (cmd_is(cmd_vld_w, cmd_w, CMD_PLL_ON))
          state_next = st_pll_on;
        else if (cmd_is(cmd_vld_w, cmd_w, CMD_OFF))
          state_next = st_transceiver_off_state;
      end
      st_tx_busy:
      begin
        if (tx_done_w)
          state_next = ret_state_reg;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= st_transceiver_off_state;
      ret_state_reg <= st_pll_on;
    end
    else
    begin
      state_reg <= state_next;
      ret_state_reg <= tx_trig_w ? state_reg : ret_state_reg;
    end
  end

  // =====================================================
  // host-writable control registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      power_reg <= POWER_RST;
      safe_mode_reg <= SAFE_RST;
      path_dis_reg <= PATH_DIS_RST;
      sens_reg <= SENS_RST;
    end
    else if (reg_wr_w)
    begin
      if (reg_addr_w == OFS_TX_POWER)
        power_reg <= byte_hold_reg[POWER_MSB:0];
      if (reg_addr_w == OFS_CTRL_TWO)
        safe_mode_reg <= byte_hold_reg[SAFE_MODE_BIT];
      if (reg_addr_w == OFS_RX_SYNC)
      begin
        path_dis_reg <= byte_hold_reg[PATH_DIS_BIT];
        sens_reg <= byte_hold_reg[SENS_MSB:0];
      end
    end
  end

  // =====================================================
  // host access pointer and read-back word for the link side
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      first_reg <= 1'b1;
      acc_reg <= ACC_REG_READ;
      ptr_reg <= 7'h00;
      rd_hold_reg <= 8'h00;
    end
    else if (sel_high_w)
      first_reg <= 1'b1;
    else if (is_cmd_byte_w)
    begin
      first_reg <= 1'b0;
      acc_reg <= byte_hold_reg[7:6];
      ptr_reg <= byte_hold_reg[7] ? {1'b0, byte_hold_reg[5:0]} : {6'h00, ~byte_hold_reg[6]}; // read runs one ahead
      rd_hold_reg <= byte_hold_reg[7] ? reg_rd_w : fb_mem[0];
    end
    else if (is_data_byte_w & ~acc_reg[1])
    begin
      ptr_reg <= ptr_reg + 7'h01;
      rd_hold_reg <= fb_mem[ptr_reg];
    end
  end

  // =====================================================
  // frame buffer: receive writes win over a host write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rx_busy_w & rx_i.data_vld)
      fb_mem[wptr_reg] <= rx_i.data;
    else if (rx_end_w)
      fb_mem[wptr_reg] <= lqi_reg;
    else if (fb_wr_w)
      fb_mem[ptr_reg] <= byte_hold_reg;
  end

  // =====================================================
  // receive bookkeeping and events
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wptr_reg <= 7'h00;
      lqi_reg <= 8'h00;
      fcs_ok_reg <= 1'b0;
      ed_reg <= 8'h00;
      locked_reg <= 1'b0;
      freq_corr_o <= 12'h000;
      rx_start_o <= 1'b0;
      frame_complete_o <= 1'b0;
    end
    else
    begin
      rx_start_o <= shr_ok_w;
      frame_complete_o <= rx_end_w | tx_done_w;
      if (shr_ok_w)
      begin
        wptr_reg <= 7'h00;
        lqi_reg <= 8'hff;
        freq_corr_o <= rx_i.freq_est;
      end
      else if (rx_busy_w & rx_i.data_vld)
      begin
        wptr_reg <= wptr_reg + 7'h01;
        lqi_reg <= 8'((({1'b0, lqi_reg} + {1'b0, rx_i.corr}) >> 1));
      end
      if (rx_end_w)
      begin
        fcs_ok_reg <= rx_i.fcs_ok;
        ed_reg <= rx_i.ed;
      end
      // set beats clear if a frame ends as the host finishes reading
      if (rx_end_w & safe_mode_reg & rx_i.fcs_ok)
        locked_reg <= 1'b1;
      else if (frame_read_done_w)
        locked_reg <= 1'b0;
    end
  end

  // =====================================================
  // transmit start-up ramp and chip stream
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i | ~tx_busy_w)
    begin
      tx_cnt_reg <= 12'h000;
      mod_on_reg <= 1'b0;
      tx_ptr_reg <= 7'h00;
      nib_reg <= 1'b0;
      chip_idx_reg <= 5'h00;
      chip_div_reg <= 6'(CHIP_CYC - 1); // first chip leaves as modulation starts
    end
    else if (!mod_on_reg)
    begin
      tx_cnt_reg <= tx_cnt_reg + 12'h001;
      mod_on_reg <= tx_cnt_reg == 12'(MOD_START_CYC - 1);
    end
    else
    begin
      chip_div_reg <= chip_tick_w ? 6'h00 : chip_div_reg + 6'h01;
      chip_idx_reg <= chip_tick_w ? chip_idx_reg + 5'h01 : chip_idx_reg;
      nib_reg <= sym_end_w ? ~nib_reg : nib_reg;
      tx_ptr_reg <= (sym_end_w & nib_reg) ? tx_ptr_reg + 7'h01 : tx_ptr_reg;
    end
  end

  // amplifier buffer first, amplifier later, both off when the frame ends
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      tx_reg <= '0;
    else
    begin
      tx_reg.pa_buf_en <= tx_busy_w & ~tx_done_w & (tx_cnt_reg >= 12'(PA_BUF_ON_CYC));
      tx_reg.pa_en <= tx_busy_w & ~tx_done_w & (tx_cnt_reg >= 12'(PA_ON_CYC));
      tx_reg.pa_level <= ~power_reg;
      tx_reg.chip <= chip_tick_w ? chips_w[5'h1f - chip_idx_reg] : tx_reg.chip;
      tx_reg.chip_stb <= chip_tick_w;
    end
  end

  assign tx_o = tx_reg;

endmodule

// >>> logic/rrb_pkg.sv
package rrb_pkg;

  // =====================================================
  // register offsets (byte address on the serial port)
  localparam logic [5:0] OFS_STATE_CMD = 6'h02;
  localparam logic [5:0] OFS_TX_POWER = 6'h05;
  localparam logic [5:0] OFS_STRENGTH = 6'h06;
  localparam logic [5:0] OFS_ENERGY = 6'h07;
  localparam logic [5:0] OFS_CTRL_TWO = 6'h0c;
  localparam logic [5:0] OFS_RX_SYNC = 6'h15;

  // =====================================================
  // field positions
  localparam int CMD_MSB = 4;
  localparam int POWER_MSB = 3;
  localparam int FCS_OK_BIT = 7;
  localparam int SAFE_MODE_BIT = 7;
  localparam int PATH_DIS_BIT = 7;
  localparam int SENS_MSB = 3;

  // =====================================================
  // reset values
  localparam logic [3:0] POWER_RST = 4'h0;
  localparam logic [3:0] SENS_RST = 4'h0;
  localparam logic SAFE_RST = 1'b0;
  localparam logic PATH_DIS_RST = 1'b0;
  // idle levels of the crossings {pin, select, byte toggle}: select rests high
  localparam logic [2:0] SYNC_IDLE = 3'b010;

  // =====================================================
  // state command field codes
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_TX_START = 5'h01;
  localparam logic [4:0] CMD_OFF = 5'h02;
  localparam logic [4:0] CMD_PLL_ON = 5'h03;
  localparam logic [4:0] CMD_RX_ON = 5'h04;
  localparam logic [4:0] CMD_AUTOACK_RX = 5'h05;
  localparam logic [4:0] CMD_RETRY_TX = 5'h06;

  // serial access kinds, top two bits of the first byte
  localparam logic [1:0] ACC_FB_READ = 2'b00;
  localparam logic [1:0] ACC_FB_WRITE = 2'b01;
  localparam logic [1:0] ACC_REG_READ = 2'b10;
  localparam logic [1:0] ACC_REG_WRITE = 2'b11;

  // =====================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MOD_START_NS = 16000;
  localparam int PA_BUF_ON_NS = 2000;
  localparam int PA_ON_NS = 8000;
  localparam int CHIP_NS = 500;
  localparam int MOD_START_CYC = (MOD_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PA_BUF_ON_CYC = (PA_BUF_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PA_ON_CYC = (PA_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHIP_CYC = CHIP_NS / CLK_PERIOD_NS;

  // symbol zero chip sequence, first chip in the top bit
  localparam logic [31:0] CHIP_BASE = 32'hd9c3522e;
  localparam logic [31:0] CHIP_ODD_MASK = 32'h55555555;

  // =====================================================
  // types
  typedef enum logic [2:0] {
    st_transceiver_off_state = 3'b000,
    st_pll_on = 3'b001,
    st_rx_on = 3'b010,
    st_rx_busy = 3'b011,
    st_autoack_rx_on = 3'b100,
    st_autoack_rx_busy = 3'b101,
    st_retry_transmit_state = 3'b110,
    st_tx_busy = 3'b111
  } rrb_state_e;

  typedef struct packed {
    logic shr_det;
    logic [7:0] rssi;
    logic [11:0] freq_est;
    logic data_vld;
    logic [7:0] data;
    logic [7:0] corr;
    logic frame_end;
    logic fcs_ok;
    logic [7:0] ed;
  } rrb_rx_s;

  typedef struct packed {
    logic pa_buf_en;
    logic pa_en;
    logic [3:0] pa_level;
    logic chip;
    logic chip_stb;
  } rrb_tx_s;

endpackage

// >>> verif/rrb_ctrl_props.sv
`timescale 1ns/1ps
module rrb_ctrl_props
  import rrb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire rrb_pkg::rrb_rx_s rx_i,
  input wire rrb_pkg::rrb_tx_s tx_o,
  input wire logic rx_start_o,
  input wire logic frame_complete_o,
  input wire logic [11:0] freq_corr_o
);
  // window around the ramp-to-modulation gap; the filter on the pin adds a few cycles
  localparam int MOD_LO = MOD_START_CYC - PA_BUF_ON_CYC - 10;
  localparam int MOD_HI = MOD_START_CYC - PA_BUF_ON_CYC + 10;
  logic in_rx_reg;
  logic in_tx_reg;
  logic got_reg;
  int mcnt_reg;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // =====================================================
  // trackers: open receive frame, transmit run, cycles to first chip
  always_ff @(posedge clk_i)
  begin
    in_rx_reg <= rst_n_i && (rx_start_o || (in_rx_reg && !frame_complete_o));
    in_tx_reg <= rst_n_i && (tx_o.pa_buf_en || (in_tx_reg && !frame_complete_o));
    got_reg <= rst_n_i && tx_o.pa_buf_en && (got_reg || tx_o.chip_stb);
    mcnt_reg <= (rst_n_i && tx_o.pa_buf_en) ? mcnt_reg + 1 : 0;
  end
  // =====================================================
  // properties
  property p_start_cause;
    rx_start_o |-> $past(rx_i.shr_det);
  endproperty
  property p_no_nested_start;
    rx_start_o |-> !in_rx_reg;
  endproperty
  property p_complete_cause;
    frame_complete_o |-> $past(rx_i.frame_end) || in_tx_reg;
  endproperty
  property p_freq_hold;
    $changed(freq_corr_o) |-> rx_start_o || $past(rx_start_o);
  endproperty
  property p_buf_before_pa;
    tx_o.pa_en |-> tx_o.pa_buf_en;
  endproperty
  property p_pa_after_buf;
    $rose(tx_o.pa_en) |-> $past(tx_o.pa_buf_en, 8);
  endproperty
  property p_mod_time;
    tx_o.chip_stb && !got_reg |-> mcnt_reg >= MOD_LO && mcnt_reg <= MOD_HI;
  endproperty
  property p_mod_late;
    tx_o.pa_buf_en && !got_reg |-> mcnt_reg <= MOD_HI;
  endproperty
  property p_chip_gap;
    tx_o.chip_stb |=> !tx_o.chip_stb [*8];
  endproperty
  property p_pa_off_end;
    frame_complete_o && in_tx_reg |=> !tx_o.pa_en && !tx_o.pa_buf_en;
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("rx start without sync");
  a_no_nested_start: assert property (p_no_nested_start) else $error("sync taken mid frame");
  a_complete_cause: assert property (p_complete_cause) else $error("stray frame complete");
  a_freq_hold: assert property (p_freq_hold) else $error("freq correction moved mid frame");
  a_buf_before_pa: assert property (p_buf_before_pa) else $error("amplifier without buffer");
  a_pa_after_buf: assert property (p_pa_after_buf) else $error("amplifier and buffer together");
  a_mod_time: assert property (p_mod_time) else $error("modulation start off time");
  a_mod_late: assert property (p_mod_late) else $error("modulation start late");
  a_chip_gap: assert property (p_chip_gap) else $error("chip strobes too close");
  a_pa_off_end: assert property (p_pa_off_end) else $error("amplifier left on");
  c_rx_start: cover property (rx_start_o);
  c_tx_done: cover property (frame_complete_o && in_tx_reg);
  c_chip: cover property (tx_o.chip_stb);
endmodule

bind rrb_ctrl rrb_ctrl_props i_rrb_ctrl_props (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .rx_i(rx_i),
  .tx_o(tx_o),
  .rx_start_o(rx_start_o),
  .frame_complete_o(frame_complete_o),
  .freq_corr_o(freq_corr_o)
);

// >>> verif/rrb_ctrl_tb.sv
`timescale 1ns/1ps
module rrb_ctrl_tb;
  import rrb_pkg::*;
  localparam logic [7:0] BASE = 8'h0a;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic slp_i = 1'b0;
  logic sclk_i, sel_n_i, mosi_i, miso_o, miso_oe_o, rx_start_o, frame_complete_o;
  rrb_rx_s rx_i = '0;
  rrb_tx_s tx_o;
  logic [11:0] freq_corr_o;
  logic [11:0] fexp;
  logic [127:0] chips;
  logic [3:0] lv [3] = '{4'h1, 4'h2, 4'hf};
  int n_fail = 0;
  int n_tests = 0;
  int nc;
  always #4 clk_i = ~clk_i;
  rrb_ctrl #(.STRENGTH_BASE(BASE), .FB_DEPTH(128)) i_rrb_ctrl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .sel_n_i(sel_n_i), .mosi_i(mosi_i),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .sleep_transmit_pin_i(slp_i), .rx_i(rx_i), .tx_o(tx_o),
    .rx_start_o(rx_start_o), .frame_complete_o(frame_complete_o), .freq_corr_o(freq_corr_o));
  rrb_host_model i_rrb_host_model (.sclk_o(sclk_i), .sel_n_o(sel_n_i), .mosi_o(mosi_i), .miso_i(miso_o));
  // =====================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_rrb_host_model.tx_q[0] = {ACC_REG_WRITE, a};
    i_rrb_host_model.tx_q[1] = d;
    i_rrb_host_model.xfer(2);
    step(8);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] exp);
    i_rrb_host_model.tx_q[0] = {ACC_REG_READ, a};
    i_rrb_host_model.xfer(3);
    chk($sformatf("register %h", a), {24'h0, exp}, {24'h0, i_rrb_host_model.rx_q[2] & m});
    step(1);
  endtask
  task automatic cmd(input logic [4:0] c, input logic [7:0] st);
    wr(OFS_STATE_CMD, {3'h0, c});
    rd(OFS_STATE_CMD, 8'hff, st);
  endtask
  // demodulator side: sync header, then two bytes and the frame end
  task automatic rx_sync(input logic [7:0] rssi, input logic acc);
    rx_i.shr_det = 1'b1;
    rx_i.rssi = rssi;
    rx_i.freq_est = {4'h5, rssi};
    if (acc)
      fexp = {4'h5, rssi};
    step(1);
    rx_i.shr_det = 1'b0;
    chk("rx start", {31'h0, acc}, {31'h0, rx_start_o});
  endtask
  task automatic rx_body(input logic fcs);
    for (int k = 1; k < 3; k++)
    begin
      rx_i.data_vld = 1'b1;
      rx_i.data = 8'hc0 + 8'(k);
      rx_i.corr = 8'hff;
      rx_i.freq_est = 12'h0;
      step(1);
      rx_i.data_vld = 1'b0;
      step(2);
    end
    chk("freq correction", {20'h0, fexp}, {20'h0, freq_corr_o});
    rx_i.frame_end = 1'b1;
    rx_i.fcs_ok = fcs;
    rx_i.ed = 8'h33;
    step(1);
    rx_i.frame_end = 1'b0;
    chk("frame complete", 1, {31'h0, frame_complete_o});
    step(2);
  endtask
  task automatic fb_check();
    i_rrb_host_model.tx_q[0] = {ACC_FB_READ, 6'h00};
    i_rrb_host_model.xfer(5);
    chk("frame byte", 32'h00c1c2ff, {8'h0, i_rrb_host_model.rx_q[2], i_rrb_host_model.rx_q[3],
      i_rrb_host_model.rx_q[4]});
    step(1);
  endtask
  function automatic logic [31:0] sym(input logic [3:0] s);
    logic [63:0] d;
    d = {CHIP_BASE, CHIP_BASE} >> (4 * s[2:0]);
    return s[3] ? d[31:0] ^ CHIP_ODD_MASK : d[31:0];
  endfunction
  // transmit of bytes 01 5a; pin edge or command as trigger
  task automatic tx_run(input logic pin, input logic [3:0] lvl, input logic [7:0] ret);
    if (pin)
      slp_i = 1'b1;
    else
      wr(OFS_STATE_CMD, {3'h0, CMD_TX_START});
    step(6);
    rd(OFS_STATE_CMD, 8'hff, 8'h07);
    nc = 0;
    for (int t = 0; t < 12000; t++)
    begin
      if (tx_o.chip_stb === 1'b1)
      begin
        if (nc == 0)
          chk("power level", {28'h0, lvl}, {28'h0, tx_o.pa_level});
        chips = {chips[126:0], tx_o.chip};
        nc++;
      end
      // last chip and frame end land together, so count before leaving
      if (frame_complete_o === 1'b1)
        break;
      step(1);
    end
    chk("chip count", 128, nc);
    chk("first symbol", sym(4'h1), chips[127:96]);
    chk("last symbol", sym(4'h5), chips[31:0]);
    slp_i = 1'b0;
    step(4);
    rd(OFS_STATE_CMD, 8'hff, ret);
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // =====================================================
  // sequence
  initial
  begin
    step(12);
    rst_n_i = 1'b1;
    step(4);
    chk("miso enable", 0, {31'h0, miso_oe_o});
    rd(OFS_TX_POWER, 8'h0f, 8'h00);
    rd(OFS_CTRL_TWO, 8'h80, 8'h00);
    rd(OFS_RX_SYNC, 8'h8f, 8'h00);
    rd(6'h3f, 8'hff, 8'h00);
    wr(OFS_ENERGY, 8'hff);
    rd(OFS_ENERGY, 8'hff, 8'h00);
    cmd(CMD_TX_START, 8'h00);
    cmd(CMD_RX_ON, 8'h02);
    // thresholds at both ends of the field: at threshold refused, one above taken
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_RX_SYNC, {4'h0, lv[i]});
      rx_sync(BASE + 8'd3 * ({4'h0, lv[i]} - 8'd1), 1'b0);
      rx_sync(BASE + 8'd3 * ({4'h0, lv[i]} - 8'd1) + 8'd1, 1'b1);
      rx_body(1'b1);
    end
    rd(OFS_ENERGY, 8'hff, 8'h33);
    rd(OFS_STRENGTH, 8'h80, 8'h80);
    fb_check();
    wr(OFS_RX_SYNC, 8'h00);
    rx_sync(8'h00, 1'b1);
    wr(OFS_RX_SYNC, 8'h80);
    rx_body(1'b0);
    rx_sync(8'hff, 1'b0);
    wr(OFS_RX_SYNC, 8'h00);
    rx_sync(8'h20, 1'b1);
    rx_body(1'b0);
    wr(OFS_CTRL_TWO, 8'h80);
    rx_sync(8'h20, 1'b1);
    rx_body(1'b0);
    rx_sync(8'h21, 1'b1);
    rx_body(1'b1);
    rx_sync(8'h22, 1'b0);
    rd(OFS_STATE_CMD, 8'hff, 8'h02);
    fb_check();
    rx_sync(8'h23, 1'b1);
    rx_body(1'b1);
    fb_check();
    wr(OFS_CTRL_TWO, 8'h00);
    cmd(CMD_OFF, 8'h00);
    cmd(CMD_AUTOACK_RX, 8'h04);
    rx_sync(8'h24, 1'b1);
    rx_body(1'b1);
    cmd(CMD_OFF, 8'h00);
    cmd(CMD_PLL_ON, 8'h01);
    cmd(CMD_AUTOACK_RX, 8'h04);
    cmd(CMD_OFF, 8'h00);
    cmd(CMD_PLL_ON, 8'h01);
    cmd(CMD_RX_ON, 8'h02);
    cmd(CMD_OFF, 8'h00);
    cmd(CMD_PLL_ON, 8'h01);
    i_rrb_host_model.tx_q[0] = {ACC_FB_WRITE, 6'h00};
    i_rrb_host_model.tx_q[1] = 8'h01;
    i_rrb_host_model.tx_q[2] = 8'h5a;
    i_rrb_host_model.xfer(3);
    wr(OFS_TX_POWER, 8'h0a);
    rd(OFS_TX_POWER, 8'h0f, 8'h0a);
    tx_run(1'b1, 4'h5, 8'h01);
    cmd(CMD_RETRY_TX, 8'h06);
    wr(OFS_TX_POWER, 8'h00);
    tx_run(1'b0, 4'hf, 8'h06);
    end_sim();
  end
  // hang guard: about 25k cycles expected, give up at 75k
  initial
  begin
    #600000;
    n_fail++;
    end_sim();
  end
endmodule

// >>> verif/rrb_host_model.sv
`timescale 1ns/1ps
module rrb_host_model #(
  parameter int HALF_NS = 16
) (
  output logic sclk_o,
  output logic sel_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  logic [7:0] tx_q [8];
  logic [7:0] rx_q [8];
  // idle: serial clock parked low, deselected
  initial
  begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one access of n bytes, msb first; miso sampled before our own rise lands
  task automatic xfer(input int n);
    sel_n_o = 1'b0;
    for (int b = 0; b < n; b++)
      for (int i = 7; i >= 0; i--)
      begin
        mosi_o = tx_q[b][i];
        #(HALF_NS);
        rx_q[b][i] = miso_i;
        sclk_o = 1'b1;
        #(HALF_NS);
        sclk_o = 1'b0;
      end
    #(HALF_NS);
    sel_n_o = 1'b1; // end of a frame read releases the buffer
    mosi_o = ~mosi_o; // released line: no stale value
    #80;
  endtask
endmodule
